// [verilog/flag_branch_defs.vh]
// Constants of the bit-clear and flag-branch execution block
`ifndef FLAG_BRANCH_DEFS_VH
`define FLAG_BRANCH_DEFS_VH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define OFS_CTRL        8'h00
`define OFS_BANK_SEL    8'h04
`define OFS_FLAGS       8'h08
`define OFS_PC          8'h0C
`define OFS_STATUS      8'h10
`define OFS_CYCLES      8'h14

// ****************************************************************
// Field positions
// ****************************************************************
`define CTRL_RUN_BIT    0
`define FLAGS_C_BIT     0
`define FLAGS_N_BIT     1
`define ST_RUN_BIT      0
`define ST_TAKEN_BIT    1
`define ST_NOP_BIT      2
`define ST_BADOP_BIT    3
`define ST_QIDX_LSB     4

// ****************************************************************
// Reset values
// ****************************************************************
`define RST_CTRL        1'b0
`define RST_BANK_SEL    4'h0
`define RST_FLAGS       2'b00
`define RST_PC          16'h0000

// ****************************************************************
// Opcodes
// ****************************************************************
`define OP_BIT_CLEAR    4'h9
`define OP_BR_CARRY     8'hE2
`define OP_BR_NO_CARRY  8'hE3
`define OP_BR_NEG       8'hE6
`define OP_BR_NOT_NEG   8'hE7

// ****************************************************************
// Timing: ref_clk cycles per quarter, quarter indices
// ****************************************************************
`define Q_DIV_DEF       8'h01
`define Q1              2'd0
`define Q2              2'd1
`define Q3              2'd2
`define Q4              2'd3

`endif

// [verilog/quarter_gen.v]
// Divider that cuts the instruction cycle into four quarter enables
`include "flag_branch_defs.vh"
`timescale 1ns/100ps
`default_nettype none

module quarter_gen #(
    parameter [7:0] DIV = `Q_DIV_DEF    // ref_clk cycles per quarter
) (
    // Clock and reset
    input  wire       ref_clk,
    input  wire       rstn,
    // Control
    input  wire       run,
    // Quarter enables
    output reg        q_en,
    output reg  [1:0] q_idx
);

    localparam [7:0] DIV_LAST = DIV - 8'h01;   // Last count of a quarter

    reg [7:0] div_cnt;                       // Clocks within a quarter

    // ****************************************************************
    // Quarter divider
    // ****************************************************************
    // Parked on Q4 while stopped so the first pulse after run opens Q1
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            div_cnt <= 8'h00;
            q_en    <= 1'b0;
            q_idx   <= `Q4;
        end else if (!run) begin
            div_cnt <= 8'h00;
            q_en    <= 1'b0;
            q_idx   <= `Q4;
        end else if (div_cnt == DIV_LAST) begin
            // Quarter boundary: pulse and advance
            div_cnt <= 8'h00;
            q_en    <= 1'b1;
            q_idx   <= q_idx + 2'd1;
        end else begin
            div_cnt <= div_cnt + 8'h01;
            q_en    <= 1'b0;
        end
    end

endmodule // quarter_gen

`default_nettype wire

// [verilog/flag_branch_bit_clear_exec.v]
// Bit-clear and carry/negative branch execution unit with APB registers
`include "flag_branch_defs.vh"
`timescale 1ns/100ps
`default_nettype none

module flag_branch_bit_clear_exec #(
    parameter [7:0]  Q_DIV       = `Q_DIV_DEF, // Clocks per quarter
    parameter [7:0]  ACC_SPLIT   = 8'h80,      // Access bank split address
    parameter [3:0]  ACC_HI_BANK = 4'hF        // Bank above the split
) (
    // Clock and reset
    input  wire        ref_clk,
    input  wire        rstn,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // Program memory
    output reg  [15:0] prog_addr,
    output reg         prog_rd,
    input  wire [15:0] prog_data,
    // Data memory
    output reg  [11:0] dmem_addr,
    output reg         dmem_re,
    input  wire [7:0]  dmem_rdata,
    output reg         dmem_we,
    output reg  [7:0]  dmem_wdata,
    // Execution status
    output reg         branch_taken,
    output reg         nop_cycle
);

    // ****************************************************************
    // Declarations
    // ****************************************************************
    wire        q_en;          // Quarter start pulse
    wire [1:0]  q_idx;         // Quarter now starting
    reg         run;           // Software run enable
    reg  [3:0]  bank_sel;      // Bank select register
    reg  [1:0]  flags;         // Carry and negative flags
    reg  [15:0] pc;            // Address of the word being fetched
    reg  [15:0] ir;            // Instruction being executed
    reg         ir_valid;      // Low in a flushed or filler cycle
    reg  [15:0] fetch_word;    // Word fetched this cycle
    reg         is_bclr;       // Decoded bit clear
    reg         take;          // Decoded taken branch
    reg  [7:0]  mod_data;      // Register value with bit cleared
    reg  [15:0] target;        // Branch target
    reg         bad_op;        // Sticky unsupported opcode
    reg  [31:0] cycles;        // Instruction cycle count
    reg  [31:0] next_rdata;    // Read mux
    reg         next_err;      // Unmapped address
    reg         cond_ok;       // Branch condition holds
    reg         br_op;         // Word is a handled branch
    wire        acc_cycle;     // APB access edge
    wire        wr_en;         // APB write edge
    wire        pc_wr;         // Software PC load
    wire        bad_clr;       // Software clear of bad_op
    wire [7:0]  bit_mask;      // One-hot of the bit to clear
    wire [15:0] offset2;       // Sign-extended offset times two

    // ****************************************************************
    // Quarter divider
    // ****************************************************************
    quarter_gen #(
        .DIV     (Q_DIV)
    ) u_quarter (
        .ref_clk (ref_clk),
        .rstn    (rstn),
        .run     (run),
        .q_en    (q_en),
        .q_idx   (q_idx)
    );

    // ****************************************************************
    // APB slave
    // ****************************************************************
    assign acc_cycle = psel & penable & pready;
    assign wr_en     = acc_cycle & pwrite & ~pslverr;
    assign pc_wr     = wr_en & (paddr == `OFS_PC) & ~run;
    assign bad_clr   = wr_en & (paddr == `OFS_STATUS) &
                       pwdata[`ST_BADOP_BIT];

    // Read mux and address decode
    always @* begin
        next_rdata = 32'h0000_0000;
        next_err   = 1'b0;
        case (paddr)
            `OFS_CTRL:     next_rdata[`CTRL_RUN_BIT] = run;
            `OFS_BANK_SEL: next_rdata[3:0] = bank_sel;
            `OFS_FLAGS:    next_rdata[1:0] = flags;
            `OFS_PC:       next_rdata[15:0] = pc;
            `OFS_STATUS: begin
                next_rdata[`ST_RUN_BIT]   = run;
                next_rdata[`ST_TAKEN_BIT] = branch_taken;
                next_rdata[`ST_NOP_BIT]   = nop_cycle;
                next_rdata[`ST_BADOP_BIT] = bad_op;
                next_rdata[`ST_QIDX_LSB+1:`ST_QIDX_LSB] = q_idx;
            end
            `OFS_CYCLES:   next_rdata = cycles;
            default:       next_err = 1'b1;
        endcase
    end

    // Answer in the first access cycle, data and error registered
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (psel & ~penable) begin
            pready  <= 1'b1;
            prdata  <= next_rdata;
            pslverr <= next_err;
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // Software registers
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            run      <= `RST_CTRL;
            bank_sel <= `RST_BANK_SEL;
            flags    <= `RST_FLAGS;
        end else if (wr_en) begin
            case (paddr)
                `OFS_CTRL:     run      <= pwdata[`CTRL_RUN_BIT];
                `OFS_BANK_SEL: bank_sel <= pwdata[3:0];
                `OFS_FLAGS:    flags    <= pwdata[1:0];
                default:       run      <= run;
            endcase
        end
    end

    // ****************************************************************
    // Decode helpers
    // ****************************************************************
    assign bit_mask = 8'h01 << ir[11:9];
    assign offset2  = {{7{ir[7]}}, ir[7:0], 1'b0};

    // Branch condition from the carry and negative flags
    always @* begin
        br_op   = 1'b1;
        cond_ok = 1'b0;
        case (ir[15:8])
            `OP_BR_CARRY:    cond_ok = flags[`FLAGS_C_BIT];
            `OP_BR_NO_CARRY: cond_ok = ~flags[`FLAGS_C_BIT];
            `OP_BR_NEG:      cond_ok = flags[`FLAGS_N_BIT];
            `OP_BR_NOT_NEG:  cond_ok = ~flags[`FLAGS_N_BIT];
            default:         br_op   = 1'b0;
        endcase
    end

    // ****************************************************************
    // Quarter sequencer
    // ****************************************************************
    // Flags are only read here, never written by execution
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            pc           <= `RST_PC;
            ir           <= 16'h0000;
            ir_valid     <= 1'b0;
            fetch_word   <= 16'h0000;
            is_bclr      <= 1'b0;
            take         <= 1'b0;
            mod_data     <= 8'h00;
            target       <= 16'h0000;
            bad_op       <= 1'b0;
            cycles       <= 32'h0000_0000;
            prog_addr    <= 16'h0000;
            prog_rd      <= 1'b0;
            dmem_addr    <= 12'h000;
            dmem_re      <= 1'b0;
            dmem_we      <= 1'b0;
            dmem_wdata   <= 8'h00;
            branch_taken <= 1'b0;
            nop_cycle    <= 1'b1;
        end else begin
            // Strobes last one clock
            prog_rd <= 1'b0;
            dmem_re <= 1'b0;
            dmem_we <= 1'b0;
            // Software clear of the sticky flag; a new set wins below
            if (bad_clr) begin
                bad_op <= 1'b0;
            end
            if (pc_wr) begin
                // Load PC while stopped; refill before executing
                pc       <= pwdata[15:0];
                ir_valid <= 1'b0;
            end else if (q_en) begin
                case (q_idx)
                    `Q1: begin
                        // Decode and start the prefetch of the next word
                        prog_addr <= pc;
                        prog_rd   <= 1'b1;
                        is_bclr   <= ir_valid &&
                                     ir[15:12] == `OP_BIT_CLEAR;
                        take      <= ir_valid & br_op & cond_ok;
                        nop_cycle <= ~ir_valid;
                        branch_taken <= 1'b0;
                        if (ir_valid && ir[15:12] != `OP_BIT_CLEAR &&
                            !br_op) begin
                            bad_op <= 1'b1;
                        end
                    end
                    `Q2: begin
                        // Read the file register, bank by access bit
                        fetch_word <= prog_data;
                        dmem_re    <= is_bclr;
                        if (ir[8]) begin
                            dmem_addr <= {bank_sel, ir[7:0]};
                        end else if (ir[7:0] < ACC_SPLIT) begin
                            dmem_addr <= {4'h0, ir[7:0]};
                        end else begin
                            dmem_addr <= {ACC_HI_BANK, ir[7:0]};
                        end
                    end
                    `Q3: begin
                        // Modify data, form the branch target
                        mod_data <= dmem_rdata & ~bit_mask;
                        target   <= pc + offset2;
                    end
                    default: begin
                        // Q4: write back or redirect, then next word
                        cycles <= cycles + 32'h0000_0001;
                        if (is_bclr) begin
                            dmem_we    <= 1'b1;
                            dmem_wdata <= mod_data;
                        end
                        if (take) begin
                            // PC write, prefetch dropped
                            pc           <= target;
                            ir_valid     <= 1'b0;
                            branch_taken <= 1'b1;
                        end else begin
                            // Sequential word runs next
                            pc       <= pc + 16'h0002;
                            ir       <= fetch_word;
                            ir_valid <= 1'b1;
                        end
                    end
                endcase
            end
        end
    end

endmodule // flag_branch_bit_clear_exec

`default_nettype wire

// [verif/fb_exec_checker.sv]
// Port assertions for the bit-clear and flag-branch execution unit
`timescale 1ns/100ps
`default_nettype none

module fb_exec_checker #(
    parameter [7:0] Q_DIV = 8'h01     // Clocks per quarter
) (
    // Clock and reset
    input wire logic        ref_clk,
    input wire logic        rstn,
    // Program and data memory
    input wire logic [15:0] prog_addr,
    input wire logic        prog_rd,
    input wire logic [11:0] dmem_addr,
    input wire logic        dmem_re,
    input wire logic [7:0]  dmem_rdata,
    input wire logic        dmem_we,
    input wire logic [7:0]  dmem_wdata,
    // Execution status
    input wire logic        branch_taken,
    input wire logic        nop_cycle
);
    localparam int QD = Q_DIV;        // One quarter
    localparam int D2 = 2 * Q_DIV;    // Two quarters
    logic [15:0]   fetch_prev;        // Address of the last fetch
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    // Remember each fetch address
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            fetch_prev <= 16'h0000;
        end else if (prog_rd) begin
            fetch_prev <= prog_addr;
        end
    end

    property p_write_back; dmem_re |-> ##D2 dmem_we; endproperty
    a_write_back: assert property (p_write_back)
        else $error("bit clear write-back missing");
    property p_addr_hold; dmem_re |=> $stable(dmem_addr) [*2]; endproperty
    a_addr_hold: assert property (p_addr_hold)
        else $error("file address moved during bit clear");
    property p_clear_only;
        dmem_we |-> ((dmem_wdata & ~$past(dmem_rdata)) == 8'h00)
            && ($countones(dmem_wdata ^ $past(dmem_rdata)) <= 1);
    endproperty
    a_clear_only: assert property (p_clear_only)
        else $error("write-back is not a single bit clear");
    property p_taken_short; $rose(branch_taken) |-> ##QD !branch_taken;
    endproperty
    a_taken_short: assert property (p_taken_short)
        else $error("taken flag held too long");
    property p_taken_nop;
        $rose(branch_taken) |-> ##QD (prog_rd && nop_cycle);
    endproperty
    a_taken_nop: assert property (p_taken_nop)
        else $error("no refill cycle after taken branch");
    property p_nop_quiet; nop_cycle |-> !dmem_re && !dmem_we; endproperty
    a_nop_quiet: assert property (p_nop_quiet)
        else $error("memory access in a no-operation cycle");
    property p_seq_fetch;
        prog_rd && !nop_cycle |-> prog_addr == fetch_prev + 16'h0002;
    endproperty
    a_seq_fetch: assert property (p_seq_fetch)
        else $error("sequential fetch skipped a word");
    property p_branch_quiet; branch_taken |-> !dmem_we && !dmem_re;
    endproperty
    a_branch_quiet: assert property (p_branch_quiet)
        else $error("data memory touched by a branch");
endmodule // fb_exec_checker

bind flag_branch_bit_clear_exec fb_exec_checker #(.Q_DIV(Q_DIV))
    fb_exec_checker_i (.ref_clk, .rstn, .prog_addr, .prog_rd, .dmem_addr,
    .dmem_re, .dmem_rdata, .dmem_we, .dmem_wdata, .branch_taken, .nop_cycle);

`default_nettype wire

// [verif/testbench.sv]
// Self-checking bench of the bit-clear and flag-branch execution unit
`timescale 1ns/100ps
`default_nettype none
`include "flag_branch_defs.vh"

module testbench;
    // ********
    // Signals
    // ********
    logic        ref_clk, rstn, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0]  paddr, dmem_rdata, dmem_wdata, rd_val, got_wdata, op, n8, f;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] prog_addr, prog_data, cur_a, cur_instr, a, tgt;
    logic [15:0] fetch_log [0:2];
    logic [11:0] dmem_addr, got_addr;
    logic        prog_rd, dmem_re, dmem_we, branch_taken, nop_cycle, tk, ab;
    logic        nop_log [0:2];
    logic [7:0]  ops [0:3];
    logic [3:0]  bs, eb;
    logic [1:0]  fl;
    int          fetches, taken_cnt, we_cnt, num_errors, checks_done, seed;

    flag_branch_bit_clear_exec flag_branch_bit_clear_exec_i (
        .ref_clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .prog_addr, .prog_rd, .prog_data, .dmem_addr,
        .dmem_re, .dmem_rdata, .dmem_we, .dmem_wdata, .branch_taken,
        .nop_cycle);

    // Clock and watchdog
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    initial begin
        #(20 * 20000);
        num_errors++;
        complete_run();
    end
    // Program word follows the fetch address within half a clock, so it
    // stands at the next quarter edge however short the quarters are
    always @(negedge ref_clk) begin
        prog_data <= (prog_addr == cur_a) ? cur_instr : 16'h0000;
    end
    // Data memory answers with the scenario's register value
    always @(posedge ref_clk) begin
        dmem_rdata <= rd_val;
    end
    // Log fetches, writes and taken flags away from the edge
    always @(negedge ref_clk) begin
        if (prog_rd) begin
            if (fetches < 3) begin
                fetch_log[fetches] = prog_addr;
                nop_log[fetches]   = nop_cycle;
            end
            fetches++;
        end
        if (dmem_we) begin
            we_cnt++;
            got_addr  = dmem_addr;
            got_wdata = dmem_wdata;
        end
        if (branch_taken) taken_cnt++;
    end

    // ********
    // Tasks
    // ********
    function automatic logic exp_taken(input logic [7:0] o,
                                       input logic [1:0] c);
        case (o)
            `OP_BR_CARRY:    return c[`FLAGS_C_BIT];
            `OP_BR_NO_CARRY: return !c[`FLAGS_C_BIT];
            `OP_BR_NEG:      return c[`FLAGS_N_BIT];
            default:         return !c[`FLAGS_N_BIT];
        endcase
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    // One APB transfer; read data and error land in rd and err
    task automatic apb(input logic w, input logic [7:0] ad,
                       input logic [31:0] d);
        int n;
        // Setup phase
        @(posedge ref_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= ad;
        pwdata  <= d;
        // Access phase, held until pready is seen high at a rising edge
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) num_errors++;
        // Answer taken at the accepting edge, request released there
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    // Run one instruction at address pa until three fetches are seen
    task automatic run_one(input logic [15:0] pa, ins, input logic [1:0] c);
        int n;
        apb(1'b1, `OFS_PC, 32'(pa));
        apb(1'b1, `OFS_FLAGS, 32'(c));
        cur_a = pa;
        cur_instr = ins;
        fetches = 0;
        taken_cnt = 0;
        we_cnt = 0;
        apb(1'b1, `OFS_CTRL, 32'h0000_0001);
        n = 0;
        while (fetches < 3 && n < 100) begin
            @(negedge ref_clk);
            n++;
        end
        if (n >= 100) num_errors++;
        apb(1'b1, `OFS_CTRL, 32'h0000_0000);
        apb(1'b0, `OFS_FLAGS, 32'h0000_0000);
        chk(rd, 32'(c));
    endtask
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ********
    // Tests
    // ********
    initial begin
        {psel, penable, pwrite, paddr, pwdata, rstn} = '0;
        {cur_a, cur_instr, rd_val, prog_data, dmem_rdata} = '0;
        {fetches, taken_cnt, we_cnt, num_errors, checks_done} = '0;
        seed = 97;
        ops = '{`OP_BR_CARRY, `OP_BR_NO_CARRY, `OP_BR_NEG, `OP_BR_NOT_NEG};
        repeat (12) @(posedge ref_clk);
        rstn <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            apb(1'b0, 8'(4 * i + 8 * (i / 4)), 32'h0000_0000);
            chk({rd[30:0], err}, 32'(i / 4));
        end
        $display("test reset values done");
        for (int i = 0; i < 16; i++) begin
            op = ops[i % 4];
            fl = 2'(i / 4);
            n8 = (i == 1) ? 8'h80 : (i == 4) ? 8'h7F : 8'($random(seed));
            a = 16'($random(seed)) & 16'hFFFE;
            run_one(a, {op, n8}, fl);
            tk = exp_taken(op, fl);
            tgt = a + 16'h0002 + {{7{n8[7]}}, n8, 1'b0};
            chk(fetch_log[1], 16'(a + 16'h0002));
            chk(fetch_log[2], tk ? tgt : 16'(a + 16'h0004));
            chk(32'(taken_cnt), 32'(tk));
            chk(32'(nop_log[2]), 32'(tk));
            $display("test branch %h flags %b done", op, fl);
        end
        for (int i = 0; i < 8; i++) begin
            f = (i == 0) ? 8'h7F : (i == 1) ? 8'h80 : 8'($random(seed));
            ab = (i < 2) ? 1'b0 : 1'($random(seed));
            bs = 4'($random(seed));
            rd_val = 8'($random(seed));
            a = 16'($random(seed)) & 16'hFFFE;
            apb(1'b1, `OFS_BANK_SEL, 32'(bs));
            run_one(a, {`OP_BIT_CLEAR, 3'(i), ab, f}, 2'($random(seed)));
            eb = ab ? bs : (f < 8'h80) ? 4'h0 : 4'hF;
            chk(32'(we_cnt), 32'h0000_0001);
            chk(32'(got_addr), 32'({eb, f}));
            chk(32'(got_wdata), 32'(rd_val & ~(8'h01 << i)));
            chk(fetch_log[2], 16'(a + 16'h0004));
            $display("test bit clear %0d done", i);
        end
        // 24 runs of three instruction cycles each, no Q4 in the stray tail
        apb(1'b0, `OFS_CYCLES, 32'h0000_0000);
        chk(rd, 32'h0000_0048);
        $display("test cycle count done");
        complete_run();
    end
endmodule // testbench

`default_nettype wire
